// File: testbench/ofs_ctl_model.sv
// register-reading controller in front of the block
`timescale 1ns/100ps
module ofs_ctl_model
    import ofs_pkg::*;
(
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // one read; released lines show the inverse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rvalid ? reg_rdata : 8'hXX;
    endtask : rd

    // one write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    // upper then lower exposure byte, back to back
    task automatic rd_exp(output logic [15:0] v);
        @(posedge clk);
        reg_addr <= OFS_ADDR_EXP_HI;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_addr <= OFS_ADDR_EXP_LO;
        #1;
        v[15:8] = reg_rdata;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= 8'hF2;
        #1;
        v[7:0] = reg_rdata;
    endtask : rd_exp
endmodule : ofs_ctl_model

// File: testbench/ofs_frame_stats_properties.sv
// port checks for the frame statistics block
`timescale 1ns/100ps
module ofs_frame_stats_properties
    import ofs_pkg::*;
#(
    parameter int unsigned SLEEP_CYCLES = OFS_SLEEP_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic frame_start,
    input wire logic pix_valid,
    input wire logic [5:0] pix_value,
    input wire logic frame_done,
    input wire logic motion_seen,
    input wire logic sensor_awake,
    input wire logic [15:0] exposure_value
);
    logic [15:0] stp;
    logic [7:0] lo_q;

    // largest legal exposure step for one frame
    assign stp = (exposure_value[15:4] == 12'h000) ? 16'h0001 :
        {4'h0, exposure_value[15:4]};

    // low byte as it stood at the upper byte read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lo_q <= 8'h00;
        else if (reg_rd && reg_addr == OFS_ADDR_EXP_HI)
            lo_q <= exposure_value[7:0];
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence hi_rd;
        reg_rd && reg_addr == OFS_ADDR_EXP_HI;
    endsequence
    sequence lo_rd;
        reg_rd && reg_addr == OFS_ADDR_EXP_LO;
    endsequence

    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read gave no data strobe");
    no_answer_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("data strobe without read");
    dump_empty_a: assert property (reg_rd && reg_addr == OFS_ADDR_DUMP
        |=> (reg_rdata[6] || reg_rdata == 8'h00))
        else $error("dump byte without valid flag not zero");
    intensity_max_a: assert property (reg_rd
        && reg_addr == OFS_ADDR_INTENSITY |=> reg_rdata <= 8'h9F)
        else $error("intensity total above its maximum");
    inv_id_a: assert property (reg_rd && reg_addr == OFS_ADDR_INV_ID
        |=> reg_rdata == {OFS_INV_ID_RSVD, OFS_INV_ID_VALUE})
        else $error("identifier register wrong");
    exp_upper_a: assert property (hi_rd
        |=> reg_rdata == ($past(exposure_value) >> 8))
        else $error("exposure upper byte wrong");
    exp_pair_a: assert property (hi_rd ##1 lo_rd |=> reg_rdata == lo_q)
        else $error("exposure lower byte not coherent");
    exp_hold_a: assert property (!frame_done |=> $stable(exposure_value))
        else $error("exposure changed outside frame end");
    exp_step_a: assert property (frame_done |=>
        exposure_value <= $past(exposure_value) + $past(stp)
        && exposure_value + $past(stp) >= $past(exposure_value))
        else $error("exposure step too large");
    exp_cap_a: assert property (exposure_value <= OFS_EXP_CAP)
        else $error("exposure above cap");
endmodule : ofs_frame_stats_properties

bind ofs_frame_stats ofs_frame_stats_properties #(
    .SLEEP_CYCLES(SLEEP_CYCLES)
) i_props (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .frame_start(frame_start),
    .pix_valid(pix_valid), .pix_value(pix_value),
    .frame_done(frame_done), .motion_seen(motion_seen),
    .sensor_awake(sensor_awake), .exposure_value(exposure_value)
);

// File: testbench/ofs_frame_stats_test.sv
// self-checking bench for the frame statistics block
`timescale 1ns/100ps
module ofs_frame_stats_test
    import ofs_pkg::*;
;
    localparam int SLP = 200;
    logic clk, rst_n, reg_rd, reg_wr, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic frame_start, pix_valid, frame_done, motion_seen, sensor_awake;
    logic [5:0] pix_value;
    logic [15:0] exposure_value, v;
    int n_errors, num_checks, cycles, sum, mx, exp_m, stp, ptr;
    int cur[1:324];
    int lims[5] = '{31, 31, 31, 55, 63};

    ofs_frame_stats #(.SLEEP_CYCLES(SLP)) i_dut (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .frame_start(frame_start),
        .pix_valid(pix_valid), .pix_value(pix_value),
        .frame_done(frame_done), .motion_seen(motion_seen),
        .sensor_awake(sensor_awake), .exposure_value(exposure_value));
    ofs_ctl_model i_ctl (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    ////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 140000)
        begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic check(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // one frame of pixels, then the gain loop reference
    task automatic frame(input int lim);
        sum = 0;
        mx = 0;
        @(posedge clk);
        frame_start <= 1'b1;
        for (int i = 1; i <= 324; i++)
        begin
            cur[i] = (lim > 63) ? 63 : $urandom % (lim + 1);
            sum += cur[i];
            mx = (cur[i] > mx) ? cur[i] : mx;
            @(posedge clk);
            frame_start <= 1'b0;
            pix_valid <= 1'b1;
            pix_value <= 6'(cur[i]);
        end
        @(posedge clk);
        pix_valid <= 1'b0;
        frame_done <= 1'b1;
        @(posedge clk);
        frame_done <= 1'b0;
        #1;
        stp = ((exp_m >> 4) == 0) ? 1 : (exp_m >> 4);
        if (mx > 57)
            exp_m = (exp_m - stp < 16) ? 16 : exp_m - stp;
        else if (mx < 53)
            exp_m = (exp_m + stp > OFS_EXP_CAP_INT) ? OFS_EXP_CAP_INT
                : exp_m + stp;
        check("exposure_value", 16'(exp_m), exposure_value);
    endtask : frame

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        {frame_start, pix_valid, frame_done, motion_seen} = 4'h0;
        pix_value = 6'h00;
        exp_m = 256;
        void'($urandom(93));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check("exposure_value", 16'h0100, exposure_value);
        i_ctl.rd(OFS_ADDR_INV_ID, d);
        check("inverted_product_code", 16'h00FA, d);
        i_ctl.rd(8'h3F, d);
        check("unmapped", 16'h0000, d);
        repeat (SLP + 5) @(posedge clk);
        #1;
        check("sensor_awake", 16'h0000, sensor_awake);
        @(posedge clk);
        motion_seen <= 1'b1;
        @(posedge clk);
        motion_seen <= 1'b0;
        #1;
        check("sensor_awake", 16'h0001, sensor_awake);
        i_ctl.wr(OFS_ADDR_CONFIG, 8'h01);
        i_ctl.rd(OFS_ADDR_CONFIG, d);
        check("forced_awake_bit", 16'h0001, d);
        // upper byte read lands on the frame end edge that moves exposure
        fork
            frame(64);
            begin
                repeat (325) @(posedge clk);
                i_ctl.rd_exp(v);
            end
        join
        check("exposure_bits", 16'h0100, v);
        i_ctl.rd(OFS_ADDR_INTENSITY, d);
        check("frame_intensity_total", 16'(sum >> 7), d);
        i_ctl.wr(OFS_ADDR_DUMP, 8'($urandom));
        i_ctl.rd(OFS_ADDR_DUMP, d);
        check("pixel_dump_port", 16'h0000, d);
        ptr = 1;
        for (int k = 0; k < 327; k++)
        begin
            frame(lims[$urandom % 5]);
            if (k == 2)
                repeat (50) @(posedge clk);
            i_ctl.rd(OFS_ADDR_DUMP, d);
            check("pixel_dump_port",
                16'({ptr == 1, 1'b1, 6'(cur[ptr])}), d);
            ptr = (ptr == 324) ? 1 : ptr + 1;
            if (k == 0)
            begin
                i_ctl.rd(OFS_ADDR_DUMP, d);
                check("pixel_dump_port", 16'h0000, d);
            end
            if (k == 1)
            begin
                i_ctl.wr(OFS_ADDR_DUMP, 8'($urandom));
                ptr = 1;
            end
            if (k < 3)
            begin
                i_ctl.rd(OFS_ADDR_INTENSITY, d);
                check("frame_intensity_total", 16'(sum >> 7), d);
                i_ctl.rd_exp(v);
                check("exposure_bits", 16'(exp_m), v);
            end
        end
        end_sim();
    end
endmodule : ofs_frame_stats_test

// File: verilog/ofs_exposure_agc.sv
// automatic gain loop for the exposure count
`timescale 1ns/100ps
module ofs_exposure_agc
    import ofs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_done,
    input wire logic [5:0] max_pixel,
    output logic [15:0] exposure
);

    logic [15:0] exp_q;
    logic [15:0] exp_d;
    logic [15:0] step;
    logic [16:0] up_sum;

    ////////////////////////////////////////////////////////////////////////
    // step is one sixteenth of the current value, never zero
    function automatic logic [15:0] ofs_step(input logic [15:0] v);
        logic [15:0] s;
        s = v >> OFS_EXP_STEP_SHIFT;
        if (s == 16'h0000)
            s = 16'h0001;
        return s;
    endfunction : ofs_step

    // next exposure from the frame's brightest pixel
    always_comb
    begin
        step = ofs_step(exp_q);
        up_sum = {1'b0, exp_q} + {1'b0, step};
        exp_d = exp_q;
        if (max_pixel > OFS_AGC_HIGH)
        begin
            if (exp_q - step < OFS_EXP_MIN || step > exp_q)
                exp_d = OFS_EXP_MIN;
            else
                exp_d = exp_q - step;
        end
        else if (max_pixel < OFS_AGC_LOW)
        begin
            if (up_sum > {1'b0, OFS_EXP_CAP})
                exp_d = OFS_EXP_CAP;
            else
                exp_d = up_sum[15:0];
        end
    end

    // at most one change per frame
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            exp_q <= OFS_EXP_RESET;
        else if (frame_done)
            exp_q <= exp_d;
    end

    assign exposure = exp_q;

endmodule : ofs_exposure_agc

// File: verilog/ofs_frame_stats.sv
// frame statistics, pixel dump and exposure readout of the motion sensor
// register map on the serial port side
// 0x00 configuration: bit 0 keeps the sensor awake, others read zero
// 0x09 frame intensity total, read only
// 0x0B pixel dump port: a write restarts the walk, a read takes a pixel
// 0x0C exposure upper byte; reading it loads the lower byte shadow
// 0x0D exposure lower byte, served from that shadow
// 0x11 inverted product code, read only
// any other address reads as zero and drops writes
//
// limits worth knowing
// frame inputs are dropped while asleep, so a dump needs the sensor kept awake by movement or forced awake
// a dump write wins over a capture in the same cycle
// a held pixel read in the first cycle of a frame waits for the next one
// the lower exposure byte read alone gives a stale value
// 324 pixels of 63 fit the 15-bit sum, so it cannot overflow
// the pixel index stops at the last pixel if a frame runs long
// results move only on the end-of-frame strobe
// the exposure cap follows the clock rate set in the package
// the sleep delay is a parameter so simulation can shorten it
`timescale 1ns/100ps
module ofs_frame_stats
    import ofs_pkg::*;
#(
    parameter int unsigned SLEEP_CYCLES = OFS_SLEEP_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    // register access from the serial port logic
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // pixel stream from the image array
    input wire logic frame_start,
    input wire logic pix_valid,
    input wire logic [5:0] pix_value,
    input wire logic frame_done,
    // movement seen by the tracking engine
    input wire logic motion_seen,
    // state and shutter towards the rest of the sensor
    output logic sensor_awake,
    output logic [15:0] exposure_value
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    // sleep and frame gating
    logic forced_awake_bit;
    logic awake_q;
    logic [OFS_SLEEP_W-1:0] idle_cnt_q;
    logic frame_go;
    logic pix_go;
    logic done_go;

    // frame statistics
    logic [8:0] pix_idx_q;
    logic [14:0] sum_q;
    logic [7:0] intensity_total_bits;
    logic [5:0] max_run_q;
    logic [5:0] max_frame;

    // exposure readout
    logic [15:0] exposure_bits;
    logic [7:0] exp_low_shadow_q;

    // pixel dump
    logic [7:0] dump_byte;
    logic dump_wr;
    logic dump_rd;

    // read port
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic rvalid_q;

    ////////////////////////////////////////////////////////////////////////
    // register decode helper
    function automatic logic ofs_hit(input logic [7:0] a,
                                     input logic [7:0] target);
        return a == target;
    endfunction : ofs_hit

    // strobes are one cycle wide, so each access arms the grabber
    // exactly once; a held write strobe would restart it every cycle
    assign dump_wr = reg_wr && ofs_hit(reg_addr, OFS_ADDR_DUMP);
    assign dump_rd = reg_rd && ofs_hit(reg_addr, OFS_ADDR_DUMP);

    ////////////////////////////////////////////////////////////////////////
    // configuration register: forced awake setting
    // other configuration bits are not kept here and read back zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            forced_awake_bit <= 1'b0;
        else if (reg_wr && ofs_hit(reg_addr, OFS_ADDR_CONFIG))
            forced_awake_bit <= reg_wdata[OFS_CFG_AWAKE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep timer; movement or forced awake keeps the sensor running
    // the count stops at the limit so it can never wrap around
    // and wake the sensor by itself
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            idle_cnt_q <= '0;
        else if (motion_seen || forced_awake_bit)
            idle_cnt_q <= '0;
        else if (idle_cnt_q < OFS_SLEEP_W'(SLEEP_CYCLES))
            idle_cnt_q <= idle_cnt_q + 1'b1;
    end

    // awake state follows the timer
    // awake out of reset so the first frames after power-up count
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            awake_q <= 1'b1;
        else if (motion_seen || forced_awake_bit)
            awake_q <= 1'b1;
        else if (idle_cnt_q >= OFS_SLEEP_W'(SLEEP_CYCLES))
            awake_q <= 1'b0;
    end

    assign sensor_awake = awake_q;

    // frames are only taken while awake
    // gating here keeps index, sum and grabber frozen together
    assign frame_go = frame_start && awake_q;
    assign pix_go = pix_valid && awake_q;
    assign done_go = frame_done && awake_q;

    ////////////////////////////////////////////////////////////////////////
    // pixel number within the frame, column order as the array scans
    // held at the last pixel so a long frame cannot run past it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pix_idx_q <= OFS_PIX_FIRST;
        else if (frame_go)
            pix_idx_q <= OFS_PIX_FIRST;
        else if (pix_go && pix_idx_q != OFS_PIX_LAST)
            pix_idx_q <= pix_idx_q + 9'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // running pixel sum and brightest pixel of the frame
    // cleared at frame start so a lost end strobe cannot mix two frames
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sum_q <= 15'h0000;
        else if (frame_go)
            sum_q <= 15'h0000;
        else if (pix_go)
            sum_q <= sum_q + {9'h000, pix_value};
    end

    // brightest pixel seen so far in this frame
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            max_run_q <= 6'h00;
        else if (frame_go)
            max_run_q <= 6'h00;
        else if (pix_go && pix_value > max_run_q)
            max_run_q <= pix_value;
    end

    // frame result registers, updated at end of frame
    // both latch on the same edge so they describe one frame
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            intensity_total_bits <= 8'h00;
            max_frame <= 6'h00;
        end
        else if (done_go)
        begin
            // divide by 128: top eight of fifteen bits
            intensity_total_bits <= sum_q[14:OFS_SUM_SHIFT];
            max_frame <= max_run_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // exposure gain loop, evaluated once per completed frame
    // the live maximum is used because the frame result register
    // is only loaded on this same edge
    // step, floor and cap of the loop live in the exposure module
    ofs_exposure_agc u_agc (
        .clk(clk),
        .rst_n(rst_n),
        .frame_done(done_go),
        .max_pixel(max_run_q),
        .exposure(exposure_bits)
    );

    assign exposure_value = exposure_bits;

    // lower byte captured when the upper byte is read
    // taken on the edge of the upper read, so a frame end one cycle
    // later cannot tear the pair
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            exp_low_shadow_q <= OFS_EXP_RESET[7:0];
        else if (reg_rd && ofs_hit(reg_addr, OFS_ADDR_EXP_HI))
            exp_low_shadow_q <= exposure_bits[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // pixel dump grabber
    // fed the gated frame strobes, so a sleeping sensor never captures
    ofs_pixel_grabber u_grab (
        .clk(clk),
        .rst_n(rst_n),
        .dump_wr(dump_wr),
        .dump_rd(dump_rd),
        .frame_start(frame_go),
        .pix_valid(pix_go),
        .pix_idx(pix_idx_q),
        .pix_value(pix_value),
        .dump_byte(dump_byte)
    );

    ////////////////////////////////////////////////////////////////////////
    // read data selection
    // unmapped addresses fall to the default and read as zero
    always_comb
    begin
        rdata_d = OFS_UNMAPPED_DATA;
        case (reg_addr)
            OFS_ADDR_CONFIG:
                rdata_d = {7'h00, forced_awake_bit};
            OFS_ADDR_INTENSITY:
                rdata_d = intensity_total_bits;
            OFS_ADDR_DUMP:
                rdata_d = dump_byte;
            OFS_ADDR_EXP_HI:
                rdata_d = exposure_bits[15:8];
            OFS_ADDR_EXP_LO:
                rdata_d = exp_low_shadow_q;
            OFS_ADDR_INV_ID:
                rdata_d = {OFS_INV_ID_RSVD, OFS_INV_ID_VALUE};
            default:
                rdata_d = OFS_UNMAPPED_DATA;
        endcase
    end

    // read data register, loaded on each read strobe
    // data holds between reads, so a slow controller may look late
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else if (reg_rd)
            rdata_q <= rdata_d;
    end

    // one-cycle mark that read data is present
    // follows every read, mapped or not
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rvalid_q <= 1'b0;
        else
            rvalid_q <= reg_rd;
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // brightest pixel of the last full frame; no register exports it yet,
    // and the gain loop reads the live maximum at the end-of-frame strobe
    // instead, so it is only folded here to mark it as unused on purpose
    logic unused_max;
    assign unused_max = ^max_frame;

endmodule : ofs_frame_stats

// File: verilog/ofs_pixel_grabber.sv
// one-pixel-per-frame grabber behind the pixel dump register
`timescale 1ns/100ps
module ofs_pixel_grabber
    import ofs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dump_wr,
    input wire logic dump_rd,
    input wire logic frame_start,
    input wire logic pix_valid,
    input wire logic [8:0] pix_idx,
    input wire logic [5:0] pix_value,
    output logic [7:0] dump_byte
);

    typedef enum logic [1:0] {G_IDLE, G_WAIT, G_GRAB, G_HELD} ofs_grab_t;

    ofs_grab_t state_q;
    logic [8:0] ptr_q;
    logic [5:0] value_q;
    logic sof_q;

    ////////////////////////////////////////////////////////////////////////
    // pointer walks 1..324 and wraps back to the first pixel
    function automatic logic [8:0] ofs_next_ptr(input logic [8:0] p);
        if (p == OFS_PIX_LAST)
            return OFS_PIX_FIRST;
        return p + 9'h001;
    endfunction : ofs_next_ptr

    ////////////////////////////////////////////////////////////////////////
    // grab sequencing; write beats read beats frame events
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= G_IDLE;
            ptr_q <= OFS_PIX_FIRST;
        end
        else if (dump_wr)
        begin
            ptr_q <= OFS_PIX_FIRST;
            state_q <= G_WAIT;
        end
        else if (dump_rd && state_q == G_HELD)
        begin
            ptr_q <= ofs_next_ptr(ptr_q);
            state_q <= G_WAIT;
        end
        else
        begin
            case (state_q)
                G_IDLE:
                    if (dump_rd)
                        state_q <= G_WAIT;
                G_WAIT:
                    if (frame_start)
                        state_q <= G_GRAB; // next available frame
                G_GRAB:
                    if (pix_valid && pix_idx == ptr_q)
                        state_q <= G_HELD;
                G_HELD:
                    state_q <= G_HELD; // held until read
                default:
                    state_q <= G_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // captured pixel and its start-of-frame mark
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value_q <= 6'h00;
            sof_q <= 1'b0;
        end
        else if (!dump_wr && state_q == G_GRAB && pix_valid
                 && pix_idx == ptr_q)
        begin
            value_q <= pix_value;
            sof_q <= (ptr_q == OFS_PIX_FIRST);
        end
    end

    // invalid answer until a capture is held
    always_comb
    begin
        dump_byte = 8'h00;
        if (state_q == G_HELD)
        begin
            dump_byte[OFS_DUMP_SOF_BIT] = sof_q;
            dump_byte[OFS_DUMP_VALID_BIT] = 1'b1;
            dump_byte[5:0] = value_q;
        end
    end

endmodule : ofs_pixel_grabber

// File: verilog/ofs_pkg.sv
// shared constants for the optical frame statistics and pixel dump block
package ofs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned OFS_CLK_HZ = 50_000_000;
    // sleep delay without movement, in milliseconds
    localparam int unsigned OFS_SLEEP_MS = 1000;
    localparam int unsigned OFS_SLEEP_CYCLES =
        OFS_CLK_HZ / 1000 * OFS_SLEEP_MS;
    localparam int unsigned OFS_SLEEP_W = 26;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFS_ADDR_CONFIG = 8'h00;
    localparam logic [7:0] OFS_ADDR_INTENSITY = 8'h09;
    localparam logic [7:0] OFS_ADDR_DUMP = 8'h0B;
    localparam logic [7:0] OFS_ADDR_EXP_HI = 8'h0C;
    localparam logic [7:0] OFS_ADDR_EXP_LO = 8'h0D;
    localparam logic [7:0] OFS_ADDR_INV_ID = 8'h11;

    ////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int unsigned OFS_CFG_AWAKE_BIT = 0;
    localparam int unsigned OFS_DUMP_SOF_BIT = 7;
    localparam int unsigned OFS_DUMP_VALID_BIT = 6;
    localparam int unsigned OFS_SUM_SHIFT = 7;
    localparam logic [7:0] OFS_UNMAPPED_DATA = 8'h00;
    // identifier value is arbitrary
    localparam logic [3:0] OFS_INV_ID_VALUE = 4'hA;
    localparam logic [3:0] OFS_INV_ID_RSVD = 4'hF;

    ////////////////////////////////////////////////////////////////////////
    // pixel array
    localparam int unsigned OFS_PIX_W = 6;
    localparam int unsigned OFS_SUM_W = 15;
    localparam int unsigned OFS_IDX_W = 9;
    localparam int unsigned OFS_ARRAY_SIDE = 18;
    localparam logic [8:0] OFS_PIX_FIRST = 9'h001;
    localparam logic [8:0] OFS_PIX_LAST = 9'h144;

    ////////////////////////////////////////////////////////////////////////
    // exposure control
    localparam logic [15:0] OFS_EXP_RESET = 16'h0100;
    localparam int unsigned OFS_EXP_CAP_INT = OFS_CLK_HZ / 1500 - 3476;
    localparam logic [15:0] OFS_EXP_CAP = 16'(OFS_EXP_CAP_INT);
    localparam logic [15:0] OFS_EXP_MIN = 16'h0010;
    localparam int unsigned OFS_EXP_STEP_SHIFT = 4;
    localparam logic [5:0] OFS_AGC_LOW = 6'h35;
    localparam logic [5:0] OFS_AGC_HIGH = 6'h39;

endpackage : ofs_pkg
